// >>> design/pmc_pkg.sv
// Package with constants and types of the power mode and emulation controller
// Notes on behaviour
// - Input clock halved before internal timing
// - Idle halts core, peripherals keep running
// - Idle leaves RAM and registers untouched
// - Enabled interrupt or reset ends Idle
// - Reset out of Idle blocks RAM writes
// - Idle drives both strobes high
// - Power Down drives both strobes low
// - Power Down stops oscillator after instruction
// - Power Down keeps RAM and registers
// - Only reset ends Power Down
// - Address strobe low at release enters emulation
// - Emulation floats port 0, pulls others weakly
// - Ordinary reset ends emulation mode
// - Reset needs two machine cycles high
package pmc_pkg;
  // Divided clock phases in one machine cycle
  localparam int unsigned MC_PHASES = 6;
  // Machine cycles that the reset pin must stay high
  localparam int unsigned RST_MC = 2;
  // Width of the phase counter
  localparam int unsigned PH_W = 3;
  // Width of the reset cycle counter
  localparam int unsigned RC_W = 2;
  // Reset values
  localparam logic [7:0] PORT_RST = 8'hff;
  localparam logic [RC_W-1:0] RC_RST = 2'h0;
  localparam logic [PH_W-1:0] PH_RST = 3'h0;

  // Operating modes, Gray coded along run, idle, power down, emulation
  typedef enum logic [1:0] {
    PMC_RUN = 2'b00,
    PMC_IDLE = 2'b01,
    PMC_PDOWN = 2'b11,
    PMC_ONCE = 2'b10
  } pmc_mode_e;
endpackage : pmc_pkg

// >>> design/pmc_clk_if.sv
// Interface carrying clock enables between the clock divider and the controller
`timescale 1ns/1ps
interface pmc_clk_if;
  logic osc_run; // Oscillator allowed to run
  logic phase_en; // One pulse per divided clock period
  logic mc_en; // One pulse per machine cycle
  modport gen (input osc_run, output phase_en, output mc_en);
  modport use_side (output osc_run, input phase_en, input mc_en);
endinterface : pmc_clk_if

// >>> design/pmc_clkgen.sv
// Divide-by-two stage and machine cycle enable generator
`timescale 1ns/1ps
module pmc_clkgen
  import pmc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  pmc_clk_if.gen ck
);
  logic div2; // Divide-by-two flip-flop
  logic next_div2;
  logic [PH_W-1:0] phase; // Phase within the machine cycle
  logic [PH_W-1:0] next_phase;
  logic phase_en; // Registered phase enable
  logic next_phase_en;
  logic mc_en; // Registered machine cycle enable
  logic next_mc_en;

  // Next values: only the halved clock advances timing, so duty cycle is irrelevant
  always_comb begin
    next_div2 = div2;
    next_phase = phase;
    next_phase_en = 1'b0;
    next_mc_en = 1'b0;
    if (ck.osc_run) begin
      next_div2 = ~div2;
      if (div2) begin
        next_phase_en = 1'b1;
        if (phase == PH_W'(MC_PHASES - 1)) begin
          next_phase = PH_RST;
          next_mc_en = 1'b1;
        end else begin
          next_phase = phase + 1'b1;
        end
      end
    end
  end

  // Register the divider state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div2 <= 1'b0;
      phase <= PH_RST;
      phase_en <= 1'b0;
      mc_en <= 1'b0;
    end else begin
      div2 <= next_div2;
      phase <= next_phase;
      phase_en <= next_phase_en;
      mc_en <= next_mc_en;
    end
  end

  assign ck.phase_en = phase_en;
  assign ck.mc_en = mc_en;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  div_half_a: assert property (phase_en |=> !phase_en)
    else $error("Phase enable ran at full input rate");
  mc_only_phase_a: assert property (mc_en |-> $past(div2) && phase == PH_RST)
    else $error("Machine cycle enable out of step with phase");
endmodule : pmc_clkgen

// >>> design/pmc_top.sv
// Power mode, reset recognition and emulation mode controller
`timescale 1ns/1ps
module pmc_top
  import pmc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic reset_pin,
  input wire logic idle_req,
  input wire logic pd_req,
  input wire logic instr_done,
  input wire logic irq_pending,
  input wire logic ext_prog,
  input wire logic core_ale,
  input wire logic core_store,
  input wire logic [7:0] core_p0,
  input wire logic core_p0_oe_n,
  input wire logic [7:0] core_p2,
  input wire logic [7:0] p2_addr,
  input wire logic ale_in,
  output logic cpu_run,
  output logic periph_run,
  output logic osc_run,
  output logic ram_wr_block,
  output logic sys_reset,
  output logic once_mode,
  output logic ale_out,
  output logic ale_oe_n,
  output logic program_store_strobe,
  output logic store_oe_n,
  output logic [7:0] p0_out,
  output logic p0_oe_n,
  output logic [7:0] p2_out,
  output logic port_weak
);
  pmc_clk_if ck ();

  pmc_mode_e mode; // Current operating mode
  pmc_mode_e next_mode;
  logic in_rst; // Internal reset held
  logic next_in_rst;
  logic [RC_W-1:0] rst_cnt; // Machine cycles seen with reset pin high
  logic [RC_W-1:0] next_rst_cnt;
  logic idle_pend; // Idle requested, waiting for instruction end
  logic next_idle_pend;
  logic pd_pend; // Power Down requested, waiting for instruction end
  logic next_pd_pend;
  logic next_cpu_run, next_periph_run, next_osc_run, next_ram_wr_block;
  logic next_ale_out, next_ale_oe_n, next_store, next_store_oe_n;
  logic [7:0] next_p0_out, next_p2_out;
  logic next_p0_oe_n, next_port_weak;

  // Divider for the internal clock enables
  pmc_clkgen u_clkgen (
    .clk(clk),
    .rstn(rstn),
    .ck(ck)
  );

  assign ck.osc_run = osc_run;

  // Mode, reset recognition and pin state decisions
  always_comb begin
    next_mode = mode;
    next_in_rst = in_rst;
    next_rst_cnt = rst_cnt;
    next_idle_pend = idle_pend | idle_req;
    next_pd_pend = pd_pend | pd_req;
    // Reset pin qualification over whole machine cycles
    if (!reset_pin) begin
      next_rst_cnt = RC_RST;
    end else if (!in_rst && ck.mc_en) begin
      if (rst_cnt == RC_W'(RST_MC - 1)) begin
        next_in_rst = 1'b1;
        next_mode = PMC_RUN;
      end else begin
        next_rst_cnt = rst_cnt + 1'b1;
      end
    end
    if (in_rst) begin
      next_idle_pend = 1'b0;
      next_pd_pend = 1'b0;
      if (!reset_pin) begin
        // Release: address strobe held low with store strobe high picks emulation
        next_in_rst = 1'b0;
        next_mode = (!ale_in && program_store_strobe) ? PMC_ONCE : PMC_RUN;
      end
    end else if (!next_in_rst) begin
      // A reset being taken wins over any mode change in the same cycle
      unique case (mode)
        PMC_RUN: begin
          // Enter a requested mode once the requesting instruction ends
          // A request raised in the entry cycle itself is kept pending
          if (instr_done && pd_pend) begin
            next_mode = PMC_PDOWN;
            next_pd_pend = pd_req;
            next_idle_pend = idle_req;
          end else if (instr_done && idle_pend) begin
            next_mode = PMC_IDLE;
            next_idle_pend = idle_req;
          end
        end
        PMC_IDLE: begin
          // Any enabled interrupt wakes the core
          if (irq_pending) begin
            next_mode = PMC_RUN;
          end
        end
        PMC_PDOWN: begin
          // Interrupts are ignored; only a qualified reset leaves
          next_mode = PMC_PDOWN;
        end
        PMC_ONCE: begin
          // Stays until an ordinary reset
          next_mode = PMC_ONCE;
        end
      endcase
    end
  end

  // Output pin and enable decisions
  always_comb begin
    next_cpu_run = 1'b1;
    next_periph_run = 1'b1;
    next_osc_run = 1'b1;
    next_ram_wr_block = 1'b0;
    next_ale_out = core_ale;
    next_ale_oe_n = 1'b0;
    next_store = core_store;
    next_store_oe_n = 1'b0;
    next_p0_out = core_p0;
    next_p0_oe_n = core_p0_oe_n;
    next_p2_out = core_p2;
    next_port_weak = 1'b0;
    if (in_rst || next_in_rst) begin
      // Under reset the core is held and the address strobe is released for strapping
      next_cpu_run = 1'b0;
      next_ale_out = 1'b1;
      next_ale_oe_n = 1'b1;
      next_store = 1'b1;
      next_p0_out = PORT_RST;
      next_p0_oe_n = 1'b1;
      next_p2_out = PORT_RST;
    end else begin
      unique case (mode)
        PMC_RUN: begin
          // Normal operation passes the core outputs through
          next_cpu_run = 1'b1;
        end
        PMC_IDLE: begin
          // Core frozen so RAM and registers keep their values
          next_cpu_run = 1'b0;
          next_ale_out = 1'b1;
          next_store = 1'b1;
          if (ext_prog) begin
            next_p0_oe_n = 1'b1;
            next_p2_out = p2_addr;
          end
          if (reset_pin) begin
            // Reset pending: core may run on, but RAM writes are barred
            next_cpu_run = 1'b1;
            next_ram_wr_block = 1'b1;
          end
        end
        PMC_PDOWN: begin
          // Oscillator and everything behind it stop; state is frozen
          next_cpu_run = 1'b0;
          next_periph_run = 1'b0;
          next_osc_run = reset_pin;
          next_ale_out = 1'b0;
          next_store = 1'b0;
          if (ext_prog) begin
            next_p0_oe_n = 1'b1;
          end
        end
        PMC_ONCE: begin
          // Pins handed over to an emulator; oscillator keeps running
          next_cpu_run = 1'b0;
          next_ale_out = 1'b1;
          next_ale_oe_n = 1'b1;
          next_store = 1'b1;
          next_store_oe_n = 1'b1;
          next_p0_oe_n = 1'b1;
          next_port_weak = 1'b1;
        end
      endcase
    end
  end

  // Register state and outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode <= PMC_RUN;
      in_rst <= 1'b1;
      rst_cnt <= RC_RST;
      idle_pend <= 1'b0;
      pd_pend <= 1'b0;
      cpu_run <= 1'b0;
      periph_run <= 1'b1;
      osc_run <= 1'b1;
      ram_wr_block <= 1'b0;
      sys_reset <= 1'b1;
      once_mode <= 1'b0;
      ale_out <= 1'b1;
      ale_oe_n <= 1'b1;
      program_store_strobe <= 1'b1;
      store_oe_n <= 1'b0;
      p0_out <= PORT_RST;
      p0_oe_n <= 1'b1;
      p2_out <= PORT_RST;
      port_weak <= 1'b0;
    end else begin
      mode <= next_mode;
      in_rst <= next_in_rst;
      rst_cnt <= next_rst_cnt;
      idle_pend <= next_idle_pend;
      pd_pend <= next_pd_pend;
      cpu_run <= next_cpu_run;
      periph_run <= next_periph_run;
      osc_run <= next_osc_run;
      ram_wr_block <= next_ram_wr_block;
      sys_reset <= next_in_rst;
      once_mode <= (next_mode == PMC_ONCE);
      ale_out <= next_ale_out;
      ale_oe_n <= next_ale_oe_n;
      program_store_strobe <= next_store;
      store_oe_n <= next_store_oe_n;
      p0_out <= next_p0_out;
      p0_oe_n <= next_p0_oe_n;
      p2_out <= next_p2_out;
      port_weak <= next_port_weak;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  idle_halt_a: assert property (mode == PMC_IDLE && !in_rst && !reset_pin && !irq_pending
      |=> !cpu_run && periph_run)
    else $error("Idle did not halt core with peripherals on");
  idle_wake_a: assert property (mode == PMC_IDLE && !in_rst && irq_pending && !reset_pin
      |=> mode == PMC_RUN ##1 cpu_run)
    else $error("Interrupt did not end Idle");
  ram_block_a: assert property (mode == PMC_IDLE && !in_rst && !next_in_rst && reset_pin
      |=> ram_wr_block && cpu_run)
    else $error("RAM writes not barred on reset out of Idle");
  idle_pins_a: assert property (mode == PMC_IDLE && !in_rst && !reset_pin
      |=> ale_out && program_store_strobe && !ale_oe_n)
    else $error("Strobes not high in Idle");
  pd_pins_a: assert property (mode == PMC_PDOWN && !in_rst && !reset_pin
      |=> !ale_out && !program_store_strobe && (p0_oe_n || !ext_prog))
    else $error("Strobes not low in Power Down");
  pd_osc_a: assert property (mode == PMC_PDOWN && !in_rst && !reset_pin
      |=> !osc_run && !cpu_run && !periph_run)
    else $error("Oscillator still running in Power Down");
  pd_exit_a: assert property (mode == PMC_PDOWN && !reset_pin
      |=> mode == PMC_PDOWN)
    else $error("Power Down left without reset");
  once_entry_a: assert property (in_rst && !reset_pin && !ale_in && program_store_strobe
      |=> mode == PMC_ONCE ##1 once_mode)
    else $error("Emulation mode not entered at strap release");
  once_pins_a: assert property (mode == PMC_ONCE && !in_rst && !reset_pin
      |=> p0_oe_n && ale_oe_n && store_oe_n && port_weak && osc_run)
    else $error("Emulation pin states wrong");
  rst_two_mc_a: assert property ($rose(in_rst) |-> $past(rst_cnt) == RC_W'(RST_MC - 1)
      && $past(reset_pin) && mode == PMC_RUN)
    else $error("Reset taken before two machine cycles");
  req_enter_a: assert property (mode == PMC_RUN && !in_rst && !reset_pin && pd_pend
      && instr_done |=> mode == PMC_PDOWN ##1 !osc_run)
    else $error("Power Down request not honoured");

  idle_cycle_c: cover property (mode == PMC_RUN ##1 mode == PMC_IDLE ##[1:50] mode == PMC_RUN);
  pd_cycle_c: cover property (mode == PMC_PDOWN ##[1:100] $rose(in_rst));
  once_c: cover property ($fell(in_rst) && mode == PMC_ONCE);
  idle_reset_c: cover property (ram_wr_block ##[1:30] in_rst);
endmodule : pmc_top

// >>> dv/pmc_far_model.sv
// Far-side model: emulator strap and address strobe pin level
`timescale 1ns/1ps
module pmc_far_model (
  input wire logic ale_out,
  input wire logic ale_oe_n,
  input wire logic program_store_strobe,
  input wire logic strap,
  output logic ale_in
);
  // Device drives the pin, or the tester pulls it low while the store strobe is high,
  // otherwise the pull-up holds it high
  assign ale_in = !ale_oe_n ? ale_out : !(strap && program_store_strobe);
endmodule // pmc_far_model

// >>> dv/power_mode_and_emulation_control_test.sv
// Self-checking testbench of the power mode and emulation controller
`timescale 1ns/1ps
module power_mode_and_emulation_control_test;
  import pmc_pkg::*;
  logic clk = 1'b0; // Oscillator input
  logic rstn = 1'b0; // Power-on reset
  logic reset_pin = 1'b0, idle_req = 1'b0, pd_req = 1'b0, instr_done = 1'b0;
  logic irq_pending = 1'b0, ext_prog = 1'b0, strap = 1'b0, ale_in;
  logic core_ale = 1'b1, core_store = 1'b1, core_p0_oe_n = 1'b0;
  logic [7:0] core_p0 = 8'ha5, core_p2 = 8'h3c, p2_addr = 8'h5a;
  logic cpu_run, periph_run, osc_run, ram_wr_block, sys_reset, once_mode;
  logic ale_out, ale_oe_n, program_store_strobe, store_oe_n, port_weak, p0_oe_n;
  logic [7:0] p0_out, p2_out;
  int bad_count = 0; // Mismatches seen
  int check_count = 0; // Comparisons made
  int cycles = 0; // Timeout counter

  // Clock at 100 MHz
  always #5 clk = ~clk;

  pmc_top u_dut (.clk(clk), .rstn(rstn), .reset_pin(reset_pin), .idle_req(idle_req),
    .pd_req(pd_req), .instr_done(instr_done), .irq_pending(irq_pending),
    .ext_prog(ext_prog), .core_ale(core_ale), .core_store(core_store), .core_p0(core_p0),
    .core_p0_oe_n(core_p0_oe_n), .core_p2(core_p2), .p2_addr(p2_addr), .ale_in(ale_in),
    .cpu_run(cpu_run), .periph_run(periph_run), .osc_run(osc_run),
    .ram_wr_block(ram_wr_block), .sys_reset(sys_reset), .once_mode(once_mode),
    .ale_out(ale_out), .ale_oe_n(ale_oe_n), .program_store_strobe(program_store_strobe),
    .store_oe_n(store_oe_n), .p0_out(p0_out), .p0_oe_n(p0_oe_n), .p2_out(p2_out),
    .port_weak(port_weak));

  pmc_far_model u_far (.ale_out(ale_out), .ale_oe_n(ale_oe_n),
    .program_store_strobe(program_store_strobe), .strap(strap), .ale_in(ale_in));

  // Prints the counts and the verdict, then ends the run
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard, far above the expected few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      $display("MISMATCH t=%0t timeout", $time);
      final_report();
    end
  end

  // Waits n edges, then steps just past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Compares one flag
  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask

  // Compares one byte
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask

  // Waits a bounded time for the internal reset to rise
  task automatic wait_rst();
    int k;
    for (k = 0; k < 40 && sys_reset !== 1'b1; k++) cyc(1);
    chk_bit(sys_reset, 1'b1, "reset not taken");
  endtask

  // Full reset pulse, held until recognised
  task automatic hw_reset();
    reset_pin = 1'b1;
    wait_rst();
    reset_pin = 1'b0;
    cyc(3);
  endtask

  // Software request followed by completion of the instruction
  task automatic enter(input logic pd);
    if (pd) pd_req = 1'b1;
    else idle_req = 1'b1;
    cyc(1);
    idle_req = 1'b0;
    pd_req = 1'b0;
    instr_done = 1'b1;
    cyc(1);
    instr_done = 1'b0;
    cyc(2);
  endtask

  // Short pulse ignored, full pulse counted over two machine cycles
  task automatic t_rst_len();
    reset_pin = 1'b1;
    cyc(12);
    reset_pin = 1'b0;
    cyc(30);
    chk_bit(sys_reset, 1'b0, "short pulse reset");
    reset_pin = 1'b1;
    // Two machine cycle pulses cannot both fall within the first 12 edges
    cyc(12);
    chk_bit(sys_reset, 1'b0, "reset too early");
    wait_rst();
    reset_pin = 1'b0;
    cyc(3);
    chk_bit(sys_reset, 1'b0, "reset stuck");
    chk_bit(cpu_run, 1'b1, "core not running");
    $display("test rst_len done");
  endtask

  // Idle from external memory, woken by interrupt
  task automatic t_idle();
    ext_prog = 1'b1;
    enter(1'b0);
    chk_bit(cpu_run, 1'b0, "idle core runs");
    chk_bit(periph_run, 1'b1, "idle peripherals stop");
    chk_bit(osc_run, 1'b1, "idle oscillator stops");
    chk_bit(ale_out, 1'b1, "idle ale");
    chk_bit(ale_oe_n, 1'b0, "idle ale not driven");
    chk_bit(program_store_strobe, 1'b1, "idle store strobe");
    chk_bit(p0_oe_n, 1'b1, "idle p0 driven");
    chk_byte(p2_out, 8'h5a, "idle p2 address");
    cyc(6);
    chk_bit(cpu_run, 1'b0, "idle left early");
    chk_bit(ram_wr_block, 1'b0, "idle ram blocked");
    irq_pending = 1'b1;
    cyc(2);
    chk_bit(cpu_run, 1'b1, "irq no wake");
    irq_pending = 1'b0;
    $display("test idle done");
  endtask

  // Idle from internal memory, ended by reset
  task automatic t_idle_rst();
    ext_prog = 1'b0;
    // The bench core writes no port or external memory after the idle request
    enter(1'b0);
    chk_byte(p2_out, 8'h3c, "idle p2 data");
    chk_byte(p0_out, 8'ha5, "idle p0 data");
    chk_bit(p0_oe_n, 1'b0, "idle p0 floats");
    reset_pin = 1'b1;
    cyc(2);
    chk_bit(ram_wr_block, 1'b1, "ram not blocked");
    chk_bit(cpu_run, 1'b1, "core frozen in reset wait");
    wait_rst();
    chk_bit(ram_wr_block, 1'b0, "ram block stays");
    reset_pin = 1'b0;
    cyc(3);
    $display("test idle_rst done");
  endtask

  // Power down, deaf to interrupts and requests, ended by reset
  task automatic t_pd();
    ext_prog = 1'b1;
    enter(1'b1);
    chk_bit(osc_run, 1'b0, "pd oscillator runs");
    chk_bit(cpu_run, 1'b0, "pd core runs");
    chk_bit(periph_run, 1'b0, "pd peripherals run");
    chk_bit(ale_out, 1'b0, "pd ale");
    chk_bit(program_store_strobe, 1'b0, "pd store strobe");
    chk_bit(p0_oe_n, 1'b1, "pd p0 driven");
    irq_pending = 1'b1;
    enter(1'b0);
    chk_bit(osc_run, 1'b0, "pd left without reset");
    chk_bit(cpu_run, 1'b0, "pd core woke");
    irq_pending = 1'b0;
    reset_pin = 1'b1;
    cyc(2);
    chk_bit(osc_run, 1'b1, "oscillator no restart");
    wait_rst();
    reset_pin = 1'b0;
    cyc(3);
    chk_bit(cpu_run, 1'b1, "no run after pd");
    chk_bit(ale_out, core_ale, "ale not normal");
    $display("test pd done");
  endtask

  // Emulation strap, pin states, and exit by ordinary reset
  task automatic t_once();
    strap = 1'b1;
    reset_pin = 1'b1;
    wait_rst();
    reset_pin = 1'b0;
    cyc(3);
    strap = 1'b0;
    chk_bit(once_mode, 1'b1, "no emulation mode");
    chk_bit(p0_oe_n, 1'b1, "emulation p0 driven");
    chk_bit(ale_oe_n, 1'b1, "emulation ale driven");
    chk_bit(store_oe_n, 1'b1, "emulation strobe driven");
    chk_bit(port_weak, 1'b1, "no weak pull");
    chk_bit(osc_run, 1'b1, "emulation oscillator");
    hw_reset();
    chk_bit(once_mode, 1'b0, "emulation stays");
    chk_bit(port_weak, 1'b0, "weak pull stays");
    $display("test once done");
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    cyc(4);
    chk_bit(sys_reset, 1'b0, "boot reset stuck");
    chk_bit(once_mode, 1'b0, "boot emulation");
    t_rst_len();
    t_idle();
    t_idle_rst();
    t_pd();
    t_once();
    final_report();
  end
endmodule // power_mode_and_emulation_control_test
